// ===== shared/pdbpm_pkg.sv
// Overview of operation
// - strap low upper pins gpio, high memory
// - strap low lower pins host, high memory
// - selection latched at reset release, kept
// - gpio bits are inputs after reset
// - upper memory data inputs after reset
// - holders enabled at reset, software switchable
// - enabled holder keeps last driven level
// - hold request tristates all data pins
// - hold clock toggles unless tristate bit set
// - off mode tristates all data pins
// - data pins tristate while reset high
// - only upper pins have gpio mode
// - lower memory data inputs after reset
// - host uses 16-bit data, inputs after reset
package pdbpm_pkg;
  // pin group width
  localparam int unsigned PDBPM_HALF_W = 16;
  // strap value choosing the memory function
  localparam logic PDBPM_STRAP_MEM = 1'h1;
  // reset values
  localparam logic PDBPM_RST_SEL = 1'h0;
  localparam logic [15:0] PDBPM_RST_ZERO16 = 16'h0000;
  localparam logic PDBPM_RST_HOLDER_EN = 1'h1;
  // gpio direction reset value: all inputs
  localparam logic [15:0] PDBPM_RST_GPIO_DIR = 16'h0000;
  // function selection
  typedef enum logic {
    PDBPM_FN_LOCAL = 1'h0,
    PDBPM_FN_MEM = 1'h1
  } pdbpm_fn_type;
endpackage

// ===== design/pdbpm_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module pdbpm_pin_mux
  import pdbpm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic function_strap_pin_i,
  input wire logic hold_req_i,
  input wire logic test_reset_i,
  input wire logic emulation_pin_zero_i,
  input wire logic emulation_off_pin_i,
  input wire logic holder_en_i,
  input wire logic holder_en_we_i,
  input wire logic [1:0] clock_out_hold_tristate_i,
  input wire logic [1:0] memory_clock_i,
  input wire logic [31:0] pin_data_i,
  input wire logic [15:0] gpio_out_i,
  input wire logic [15:0] gpio_dir_i,
  input wire logic gpio_dir_we_i,
  input wire logic [31:0] mem_data_out_i,
  input wire logic mem_data_oe_i,
  input wire logic [15:0] host_data_out_i,
  input wire logic host_data_oe_i,
  output logic [31:0] pin_data_o,
  output logic [31:0] pin_data_oe_o,
  output logic [31:0] pin_hold_o,
  output logic [1:0] memory_clock_out_o,
  output logic [1:0] memory_clock_out_oe_o,
  output logic mem_select_o,
  output logic holder_en_o,
  output logic [15:0] gpio_dir_o,
  output logic [15:0] gpio_in_o,
  output logic [31:0] mem_data_in_o,
  output logic [15:0] host_data_in_o
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  pdbpm_fn_type fn_sel; // latched function
  logic rst_seen; // strap capture pending
  logic [31:0] last_drv; // level last driven per pin
  logic [31:0] next_oe; // enables before tristate overrides
  logic [31:0] next_data; // pin data source
  logic tri_all; // global tristate
  ////////////////////////////////////////////////////////////////////////////
  // strap capture: async reset loads constant, strap sampled on first clean edge
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rst_seen <= 1'h1;
      fn_sel <= PDBPM_FN_LOCAL;
    end else if (rst_seen) begin
      // first sample after release fixes the function until next reset
      rst_seen <= 1'h0;
      fn_sel <= pdbpm_fn_type'(function_strap_pin_i);
    end
  end
  // register copy of selection for users
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mem_select_o <= PDBPM_RST_SEL;
    end else begin
      mem_select_o <= (fn_sel == PDBPM_FN_MEM);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // bus holder control
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      holder_en_o <= PDBPM_RST_HOLDER_EN;
    end else if (holder_en_we_i) begin
      holder_en_o <= holder_en_i;
    end
  end
  // gpio direction: 1 = output, inputs after reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      gpio_dir_o <= PDBPM_RST_GPIO_DIR;
    end else if (gpio_dir_we_i && fn_sel == PDBPM_FN_LOCAL && !rst_seen) begin
      gpio_dir_o <= gpio_dir_i;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // tristate conditions
  always_comb begin
    tri_all = rst_i || rst_seen;
    if (hold_req_i) begin
      tri_all = 1'h1;
    end
    if (!test_reset_i && emulation_pin_zero_i && !emulation_off_pin_i) begin
      tri_all = 1'h1;
    end
  end
  // route enable and data source by latched function
  always_comb begin
    if (fn_sel == PDBPM_FN_MEM) begin
      // memory unit owns all 32 pins; inputs unless it drives
      next_oe = {32{mem_data_oe_i}};
      next_data = mem_data_out_i;
    end else begin
      // upper half gpio, lower half host 16-bit data
      next_oe = {gpio_dir_o, {16{host_data_oe_i}}};
      next_data = {gpio_out_i, host_data_out_i};
    end
  end
  // pin outputs registered; data outputs from flip-flops
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_data_oe_o <= {PDBPM_RST_ZERO16, PDBPM_RST_ZERO16};
      pin_data_o <= {PDBPM_RST_ZERO16, PDBPM_RST_ZERO16};
    end else begin
      pin_data_oe_o <= tri_all ? 32'h0000_0000 : next_oe;
      pin_data_o <= next_data;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // holder memory: remember level driven, keep it while undriven
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      last_drv <= {PDBPM_RST_ZERO16, PDBPM_RST_ZERO16};
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (pin_data_oe_o[i]) begin
          last_drv[i] <= pin_data_o[i];
        end
      end
    end
  end
  // keeper drive: active only when holder on and pin undriven
  always_comb begin
    pin_hold_o = holder_en_o ? (~pin_data_oe_o & last_drv) : 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // memory clocks: pass through; tristate in hold only if bit set
  always_comb begin
    memory_clock_out_o = memory_clock_i;
    for (int k = 0; k < 2; k++) begin
      memory_clock_out_oe_o[k] = !(hold_req_i && clock_out_hold_tristate_i[k]);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // input routing to owning unit only
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      gpio_in_o <= PDBPM_RST_ZERO16;
      host_data_in_o <= PDBPM_RST_ZERO16;
      mem_data_in_o <= {PDBPM_RST_ZERO16, PDBPM_RST_ZERO16};
    end else begin
      gpio_in_o <= (fn_sel == PDBPM_FN_LOCAL) ? pin_data_i[31:16] : 16'h0000;
      host_data_in_o <= (fn_sel == PDBPM_FN_LOCAL) ? pin_data_i[15:0] : 16'h0000;
      mem_data_in_o <= (fn_sel == PDBPM_FN_MEM) ? pin_data_i : 32'h0000_0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence release_s;
    $fell(rst_seen);
  endsequence
  strap_latch_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    release_s |-> (fn_sel == $past(function_strap_pin_i)))
    else $error("selection not taken from strap");
  sel_stable_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !rst_seen && !$past(rst_seen) |-> $stable(fn_sel))
    else $error("selection changed after release");
  hold_tri_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    hold_req_i |=> pin_data_oe_o == 32'h0000_0000)
    else $error("pins driven in hold");
  off_tri_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!test_reset_i && emulation_pin_zero_i && !emulation_off_pin_i)
    |=> pin_data_oe_o == 32'h0000_0000)
    else $error("pins driven in off mode");
  clk_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    hold_req_i |-> memory_clock_out_oe_o == ~clock_out_hold_tristate_i)
    else $error("clock enable wrong in hold");
  keeper_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    holder_en_o && pin_data_oe_o[0] ##1 !pin_data_oe_o[0] && holder_en_o
    |-> pin_hold_o[0] == $past(pin_data_o[0]))
    else $error("holder lost level");
  gpio_only_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    fn_sel == PDBPM_FN_MEM |=> $stable(gpio_dir_o))
    else $error("gpio direction changed in memory mode");
  release_tri_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    release_s |-> pin_data_oe_o == 32'h0000_0000)
    else $error("pins driven at release");
  ////////////////////////////////////////////////////////////////////////////
  // the two in-reset checks run without the disable; two reset samples in a row
  // keep them off the unknown state before the first reset edge
  sequence in_reset_s;
    rst_i ##1 rst_i;
  endsequence
  reset_tri_a: assert property (@(posedge clk_sys_i)
    in_reset_s |-> pin_data_oe_o == 32'h0000_0000)
    else $error("pins driven during reset");
  holder_rst_a: assert property (@(posedge clk_sys_i)
    in_reset_s |-> holder_en_o)
    else $error("holders off during reset");
  gpio_rst_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    release_s |-> gpio_dir_o == PDBPM_RST_GPIO_DIR)
    else $error("gpio not inputs after reset");
  // latched selection as seen by the routing checks
  sequence mem_sel_s;
    fn_sel == PDBPM_FN_MEM;
  endsequence
  sequence local_sel_s;
    fn_sel == PDBPM_FN_LOCAL;
  endsequence
  mem_idle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mem_sel_s ##0 !mem_data_oe_i |=> pin_data_oe_o == 32'h0000_0000)
    else $error("memory pins driven while idle");
  mem_data_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mem_sel_s |=> pin_data_o == $past(mem_data_out_i))
    else $error("memory data not routed to pins");
  mem_in_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mem_sel_s |=> gpio_in_o == PDBPM_RST_ZERO16 && host_data_in_o == PDBPM_RST_ZERO16)
    else $error("local units see pins in memory mode");
  host_idle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    local_sel_s ##0 !host_data_oe_i |=> pin_data_oe_o[15:0] == PDBPM_RST_ZERO16)
    else $error("lower pins driven without host");
  local_in_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    local_sel_s |=> mem_data_in_o == {PDBPM_RST_ZERO16, PDBPM_RST_ZERO16})
    else $error("memory unit sees pins in local mode");
  gpio_oe_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    local_sel_s ##0 !tri_all |=> pin_data_oe_o[31:16] == $past(gpio_dir_o))
    else $error("upper pin enables do not follow gpio direction");
endmodule
`default_nettype wire

// ===== verification/pdbpm_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// far side of the data pins: memory device or host
module pdbpm_far_side (
  input wire logic clk_sys_i,
  input wire logic [31:0] pin_data_o,
  input wire logic [31:0] pin_data_oe_o,
  input wire logic holder_en_o,
  input wire logic [31:0] drive_i,
  input wire logic drive_oe_i,
  output logic [31:0] wire_o
);
  logic [31:0] last = 32'h0; // level last seen on the wire
  // wire level; a floating pin with no keeper flips so a stale value never matches
  always_comb begin
    for (int b = 0; b < 32; b++) begin
      if (pin_data_oe_o[b]) wire_o[b] = pin_data_o[b];
      else if (drive_oe_i) wire_o[b] = drive_i[b];
      else wire_o[b] = holder_en_o ? last[b] : ~last[b];
    end
  end
  // keeper memory
  always_ff @(posedge clk_sys_i) begin
    last <= wire_o;
  end
endmodule
`default_nettype wire

// ===== verification/tb_pdbpm_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pdbpm_pin_mux;
  import pdbpm_pkg::*;
  logic clk_sys_i = 1'h0, rst_i = 1'h1, strap = 1'h0, hold = 1'h0, trst = 1'h1;
  logic emulation_pin_zero = 1'h0, emuoff = 1'h1, hen = 1'h1, hwe = 1'h0, dwe = 1'h0;
  logic moe = 1'h0, hoe = 1'h0, poe = 1'h0, msel, hen_o; // strobes and enables
  logic [1:0] ktz = 2'h0, mclk = 2'h3, ck, ckoe; // memory clocks
  logic [15:0] gout = 16'h0, gdir = 16'h0, hout = 16'h0, gdo, gin, hin;
  logic [31:0] mout = 32'h0, pdrv = 32'h0, pin, pdo, poe_o, phold, min;
  int n_errors = 0, compares = 0;
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  pdbpm_pin_mux dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .function_strap_pin_i(strap),
    .hold_req_i(hold), .test_reset_i(trst), .emulation_pin_zero_i(emulation_pin_zero),
    .emulation_off_pin_i(emuoff), .holder_en_i(hen), .holder_en_we_i(hwe),
    .clock_out_hold_tristate_i(ktz), .memory_clock_i(mclk), .pin_data_i(pin),
    .gpio_out_i(gout), .gpio_dir_i(gdir), .gpio_dir_we_i(dwe), .mem_data_out_i(mout),
    .mem_data_oe_i(moe), .host_data_out_i(hout), .host_data_oe_i(hoe), .pin_data_o(pdo),
    .pin_data_oe_o(poe_o), .pin_hold_o(phold), .memory_clock_out_o(ck),
    .memory_clock_out_oe_o(ckoe), .mem_select_o(msel), .holder_en_o(hen_o),
    .gpio_dir_o(gdo), .gpio_in_o(gin), .mem_data_in_o(min), .host_data_in_o(hin));
  pdbpm_far_side far (.clk_sys_i(clk_sys_i), .pin_data_o(pdo), .pin_data_oe_o(poe_o),
    .holder_en_o(hen_o), .drive_i(pdrv), .drive_oe_i(poe), .wire_o(pin));
  ////////////////////////////////////////////////////////////////
  // drives land on rising edges, looks happen on the falling edge
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // five-cycle reset with the strap held, checked mid-reset
  task do_reset(input logic s);
    cyc(1);
    rst_i <= 1'h1;
    strap <= s;
    cyc(2);
    @(negedge clk_sys_i);
    chk(poe_o, 32'h0);
    chk(hen_o, 1'h1);
    cyc(3);
    rst_i <= 1'h0;
    cyc(2);
    @(negedge clk_sys_i);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_errors++;
    final_report;
  end
  initial begin
    do_reset(1'h1);
    chk(msel, 1'h1);
    chk(poe_o, 32'h0);
    cyc(1);
    pdrv <= 32'ha5a55a5a;
    poe <= 1'h1;
    strap <= 1'h0;
    cyc(2);
    @(negedge clk_sys_i);
    chk(min, 32'ha5a55a5a);
    chk({gin, hin}, 32'h0);
    chk(msel, 1'h1);
    cyc(1);
    poe <= 1'h0;
    mout <= 32'h1234fedc;
    moe <= 1'h1;
    dwe <= 1'h1;
    gdir <= 16'hffff;
    cyc(2);
    @(negedge clk_sys_i);
    chk(pdo, 32'h1234fedc);
    chk(poe_o, 32'hffffffff);
    chk(gdo, 16'h0);
    cyc(1);
    dwe <= 1'h0;
    hold <= 1'h1;
    ktz <= 2'h1;
    mclk <= 2'h1;
    cyc(2);
    @(negedge clk_sys_i);
    chk(poe_o, 32'h0);
    chk({ckoe, ck}, 4'h9);
    cyc(1);
    hold <= 1'h0;
    trst <= 1'h0;
    emulation_pin_zero <= 1'h1;
    emuoff <= 1'h0;
    cyc(2);
    @(negedge clk_sys_i);
    chk(poe_o, 32'h0);
    cyc(1);
    trst <= 1'h1;
    cyc(2);
    @(negedge clk_sys_i);
    chk(poe_o, 32'hffffffff);
    cyc(1);
    moe <= 1'h0;
    cyc(2);
    @(negedge clk_sys_i);
    chk(phold, 32'h1234fedc);
    do_reset(1'h0);
    chk({msel, gdo}, 17'h0);
    chk(poe_o, 32'h0);
    cyc(1);
    dwe <= 1'h1;
    gdir <= 16'hff00;
    gout <= 16'hc3c3;
    hout <= 16'h9e9e;
    hoe <= 1'h1;
    hwe <= 1'h1;
    hen <= 1'h0;
    cyc(2);
    @(negedge clk_sys_i);
    chk(gdo, 16'hff00);
    chk(pdo & poe_o, 32'hc3009e9e);
    chk(poe_o, 32'hff00ffff);
    chk(hen_o, 1'h0);
    chk(phold, 32'h0);
    cyc(1);
    {dwe, hwe, hoe, poe} <= 4'h1;
    pdrv <= 32'h0055aa11;
    cyc(2);
    @(negedge clk_sys_i);
    chk(gin & 16'h00ff, 16'h0055);
    chk(hin, 16'haa11);
    chk(min, 32'h0);
    final_report;
  end
endmodule
`default_nettype wire
